// ==== hw/core_timing_consts.vh ====
// constants for the core instruction timing and memory map decoder
// assumes one core clock per instruction cycle, synchronous inputs
// Function
// RULE1 - one instruction cycle equals one clock
// RULE2 - exchange with register: one byte, one cycle
// RULE3 - indirect or direct exchange takes two cycles
// RULE4 - carry clear/set/complement: one byte, one cycle
// RULE5 - direct bit operations: two bytes, two cycles
// RULE6 - indirect jump via pointer: one byte, three cycles
// RULE7 - absolute call/jump and short jump: three cycles
// RULE8 - two-byte conditional branches take three cycles
// RULE9 - long jump, long call, returns: four cycles
// RULE10 - three-byte branches take four cycles
// RULE11 - interrupt vector long call takes three cycles
// RULE12 - external data move: four plus wait count
// RULE13 - access pin high at reset: internal flash
// RULE14 - no external code space, no rollover
// RULE15 - only lower 56 kilobytes reprogrammable at run time
// RULE16 - data flash reached only via control registers
// RULE17 - lower RAM half: direct and indirect
// RULE18 - upper half direct hits special registers instead
// RULE19 - bottom 32 bytes: four register banks
// RULE20 - bytes 20H-2FH bit addressable, bits 00H-7FH
// RULE21 - reset pointer 07H, pre-increment, first 08H
// RULE22 - stack anywhere, extended up to 2048 bytes
// RULE23 - onchip extended RAM up to 0007FFH when enabled
// RULE24 - wait count 0 to 7, default zero
// RULE25 - extended stack rolls FFH to 0100H
`ifndef CORE_TIMING_CONSTS_VH
`define CORE_TIMING_CONSTS_VH
// opcode classes
`define OPC_NOP 8'h00
`define OPC_AJMP_MASK 8'h1f
`define OPC_AJMP 8'h01
`define OPC_ACALL 8'h11
`define OPC_LJMP 8'h02
`define OPC_LCALL 8'h12
`define OPC_RET 8'h22
`define OPC_RETI 8'h32
`define OPC_JBC 8'h10
`define OPC_JB 8'h20
`define OPC_JNB 8'h30
`define OPC_JC 8'h40
`define OPC_JNC 8'h50
`define OPC_JZ 8'h60
`define OPC_JNZ 8'h70
`define OPC_SJMP 8'h80
`define OPC_JMP_IND 8'h73
`define OPC_ORL_CB 8'h72
`define OPC_ANL_CB 8'h82
`define OPC_MOV_BC 8'h92
`define OPC_ORL_CNB 8'ha0
`define OPC_MOV_CB 8'ha2
`define OPC_ANL_CNB 8'hb0
`define OPC_CPL_B 8'hb2
`define OPC_CPL_C 8'hb3
`define OPC_CJNE_AI 8'hb4
`define OPC_CJNE_AD 8'hb5
`define OPC_CJNE_RI 8'hb6
`define OPC_CJNE_RI1 8'hb7
`define OPC_CLR_B 8'hc2
`define OPC_CLR_C 8'hc3
`define OPC_XCH_D 8'hc5
`define OPC_XCH_I0 8'hc6
`define OPC_XCH_I1 8'hc7
`define OPC_SETB_B 8'hd2
`define OPC_SETB_C 8'hd3
`define OPC_DJNZ_D 8'hd5
`define OPC_XCHD_I0 8'hd6
`define OPC_XCHD_I1 8'hd7
`define OPC_MOVX_A_DP 8'he0
`define OPC_MOVX_A_I0 8'he2
`define OPC_MOVX_A_I1 8'he3
`define OPC_MOVX_DP_A 8'hf0
`define OPC_MOVX_I0_A 8'hf2
`define OPC_MOVX_I1_A 8'hf3
`define OPC_HI_MASK 8'hf8
`define OPC_XCH_R 8'hc8
`define OPC_DJNZ_R 8'hd8
`define OPC_CJNE_R 8'hb8
// cycle counts
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
// memory map
`define CODE_TOP 16'hf7ff
`define CODE_USER_TOP 16'hdfff
`define DFLASH_TOP 12'hfff
`define RAM_UPPER_BIT 7
`define BANK_TOP 8'h1f
`define BITAREA_LO 8'h20
`define BITAREA_HI 8'h2f
`define SP_RESET 8'h07
`define SP_XWRAP 11'h100
`define XRAM_TOP 24'h0007ff
`define WAIT_RESET 3'h0
`endif

// ==== hw/core_cycle_lookup.v ====
// opcode to byte/cycle count lookup
// assumes the opcode is stable for the cycle it is looked up
`timescale 1ns/100ps
`include "core_timing_consts.vh"
module core_cycle_lookup (
   // opcode in
   input wire [7:0] opcode_in,
   input wire from_irq_in,
   input wire [2:0] wait_in,
   // counts out
   output reg [1:0] bytes_out,
   output reg [3:0] cycles_out,
   output reg known_out
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   always @* begin
      bytes_out = 2'h1;
      cycles_out = {1'b0, `CYC_1};
      known_out = 1'b1;
      if ((opcode_in & `OPC_HI_MASK) == `OPC_XCH_R) begin
         cycles_out = {1'b0, `CYC_1}; // RULE2
      end else if ((opcode_in & `OPC_HI_MASK) == `OPC_DJNZ_R) begin
         bytes_out = 2'h2;
         cycles_out = {1'b0, `CYC_3}; // RULE8
      end else if ((opcode_in & `OPC_HI_MASK) == `OPC_CJNE_R) begin
         bytes_out = 2'h3;
         cycles_out = {1'b0, `CYC_4}; // RULE10
      end else if ((opcode_in & `OPC_AJMP_MASK) == `OPC_AJMP ||
                   (opcode_in & `OPC_AJMP_MASK) == `OPC_ACALL) begin
         bytes_out = 2'h2;
         cycles_out = {1'b0, `CYC_3}; // RULE7
      end else begin
         case (opcode_in)
            `OPC_NOP, `OPC_CLR_C, `OPC_SETB_C, `OPC_CPL_C: begin
               cycles_out = {1'b0, `CYC_1}; // RULE4
            end
            `OPC_XCH_I0, `OPC_XCH_I1, `OPC_XCHD_I0, `OPC_XCHD_I1: begin
               cycles_out = {1'b0, `CYC_2}; // RULE3
            end
            `OPC_XCH_D: begin
               bytes_out = 2'h2;
               cycles_out = {1'b0, `CYC_2}; // RULE3
            end
            `OPC_CLR_B, `OPC_SETB_B, `OPC_CPL_B, `OPC_ANL_CB, `OPC_ANL_CNB,
            `OPC_ORL_CB, `OPC_ORL_CNB, `OPC_MOV_CB, `OPC_MOV_BC: begin
               bytes_out = 2'h2;
               cycles_out = {1'b0, `CYC_2}; // RULE5
            end
            `OPC_JMP_IND: begin
               cycles_out = {1'b0, `CYC_3}; // RULE6
            end
            `OPC_SJMP: begin
               bytes_out = 2'h2;
               cycles_out = {1'b0, `CYC_3}; // RULE7
            end
            `OPC_JC, `OPC_JNC, `OPC_JZ, `OPC_JNZ: begin
               bytes_out = 2'h2;
               cycles_out = {1'b0, `CYC_3}; // RULE8
            end
            `OPC_LJMP: begin
               bytes_out = 2'h3;
               cycles_out = {1'b0, `CYC_4}; // RULE9
            end
            `OPC_LCALL: begin
               bytes_out = 2'h3;
               // vectoring call is one cycle shorter
               cycles_out = from_irq_in ? {1'b0, `CYC_3} : {1'b0, `CYC_4}; // RULE11
            end
            `OPC_RET, `OPC_RETI: begin
               cycles_out = {1'b0, `CYC_4}; // RULE9
            end
            `OPC_JB, `OPC_JNB, `OPC_JBC, `OPC_CJNE_AI, `OPC_CJNE_AD,
            `OPC_CJNE_RI, `OPC_CJNE_RI1, `OPC_DJNZ_D: begin
               bytes_out = 2'h3;
               cycles_out = {1'b0, `CYC_4}; // RULE10
            end
            `OPC_MOVX_A_DP, `OPC_MOVX_A_I0, `OPC_MOVX_A_I1,
            `OPC_MOVX_DP_A, `OPC_MOVX_I0_A, `OPC_MOVX_I1_A: begin
               cycles_out = {1'b0, `CYC_4} + {1'b0, wait_in}; // RULE12
            end
            default: begin
               known_out = 1'b0; // outside this decoder's classes
            end
         endcase
      end
   end
endmodule // core_cycle_lookup

// ==== hw/core_cycle_timing_and_memory_map.v ====
// instruction cycle sequencer, stack pointer and memory map decoder
// assumes all inputs synchronous to REF_CLK_IN; one clock per cycle
`timescale 1ns/100ps
`include "core_timing_consts.vh"
module core_cycle_timing_and_memory_map #(
   parameter WAIT_W = 3
) (
   // clock and reset
   input wire REF_CLK_IN,
   input wire RST_IN,
   // strap
   input wire EXTERNAL_ACCESS_PIN_IN,
   // instruction issue
   input wire ISSUE_IN,
   input wire [7:0] OPCODE_IN,
   input wire FROM_IRQ_IN,
   // configuration
   input wire [WAIT_W-1:0] MOVX_WAIT_COUNT_IN,
   input wire WAIT_WE_IN,
   input wire ONCHIP_XRAM_ENABLE_IN,
   input wire EXT_STACK_ENABLE_IN,
   // stack operations
   input wire STACK_PUSH_IN,
   input wire STACK_POP_IN,
   input wire SP_WE_IN,
   input wire [10:0] SP_WDATA_IN,
   // data memory address to classify
   input wire [7:0] DATA_ADDR_IN,
   input wire DATA_INDIRECT_IN,
   input wire [23:0] DATA_ADDRESS_POINTER_IN,
   // code address and flash write check
   input wire [15:0] CODE_ADDR_IN,
   input wire FLASH_WRITE_IN,
   // sequencing status
   output reg BUSY_OUT,
   output reg DONE_OUT,
   output reg [3:0] CYCLES_OUT,
   output reg [1:0] BYTES_OUT,
   output reg UNKNOWN_OUT,
   // configuration status
   output reg INTERNAL_CODE_OUT,
   output reg [WAIT_W-1:0] MOVX_WAIT_COUNT_OUT,
   // stack
   output reg [7:0] STACK_TOP_POINTER_OUT,
   output reg [2:0] STACK_POINTER_UPPER_BITS_OUT,
   // data map
   output reg SEL_RAM_OUT,
   output reg SEL_SFR_OUT,
   output reg SEL_BANK_OUT,
   output reg [1:0] BANK_NUM_OUT,
   output reg [2:0] REG_NUM_OUT,
   output reg SEL_BITAREA_OUT,
   output reg [3:0] BIT_BYTE_OUT,
   // extended data map
   output reg XRAM_ONCHIP_OUT,
   output reg XRAM_OFFCHIP_OUT,
   // code map
   output reg CODE_VALID_OUT,
   output reg FLASH_WRITE_OK_OUT
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 2'b01; // waiting for an issue
   localparam ST_RUN = 2'b10; // counting cycles

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg [1:0] state_q; // sequencer state
   reg [1:0] state_d;
   reg [3:0] count_q; // cycles left
   reg [3:0] count_d;
   reg [WAIT_W-1:0] wait_q; // programmed wait states
   reg strap_done_q; // strap taken after release
   reg [10:0] sp_q; // extended stack pointer
   reg [10:0] sp_d;
   wire [1:0] lk_bytes; // lookup byte count
   wire [3:0] lk_cycles; // lookup cycle count
   wire lk_known; // opcode in known class

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // next stack pointer up, with optional roll into extended RAM
   function [10:0] sp_inc;
      input [10:0] sp;
      input ext;
      begin
         if (!ext) begin
            sp_inc = {3'h0, sp[7:0] + 8'h01}; // plain wrap to 00H
         end else if (sp[7:0] == 8'hff && sp[10:8] == 3'h0) begin
            sp_inc = `SP_XWRAP; // RULE25
         end else begin
            sp_inc = sp + 11'h001; // RULE22
         end
      end
   endfunction

   // next stack pointer down
   function [10:0] sp_dec;
      input [10:0] sp;
      input ext;
      begin
         if (!ext) begin
            sp_dec = {3'h0, sp[7:0] - 8'h01};
         end else if (sp == `SP_XWRAP) begin
            sp_dec = 11'h0ff; // back out of extended RAM
         end else begin
            sp_dec = sp - 11'h001;
         end
      end
   endfunction

   // ----------------------------------------
   // count lookup
   // ----------------------------------------
   core_cycle_lookup u_lookup (
      .opcode_in(OPCODE_IN),
      .from_irq_in(FROM_IRQ_IN),
      .wait_in(wait_q),
      .bytes_out(lk_bytes),
      .cycles_out(lk_cycles),
      .known_out(lk_known)
   );

   // ----------------------------------------
   // sequencer next state
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         ST_IDLE: begin
            if (ISSUE_IN && lk_cycles > 4'h1) begin
               state_d = ST_RUN; // multi-cycle instruction
               count_d = lk_cycles - 4'h1;
            end
         end
         ST_RUN: begin
            count_d = count_q - 4'h1; // one clock per cycle RULE1
            if (count_q == 4'h1) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            count_d = 4'h0;
         end
      endcase
   end

   // ----------------------------------------
   // sequencer registers and status
   // ----------------------------------------
   always @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_q <= ST_IDLE;
         count_q <= 4'h0;
         BUSY_OUT <= 1'b0;
         DONE_OUT <= 1'b0;
         CYCLES_OUT <= 4'h0;
         BYTES_OUT <= 2'h0;
         UNKNOWN_OUT <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         BUSY_OUT <= (state_d == ST_RUN);
         // done pulses on the last cycle of an instruction
         // one- and two-cycle ops end right after their issue edge
         DONE_OUT <= (state_q == ST_IDLE && ISSUE_IN && lk_cycles <= 4'h2) ||
                     (state_q == ST_RUN && count_q == 4'h2);
         if (state_q == ST_IDLE && ISSUE_IN) begin
            CYCLES_OUT <= lk_cycles; // RULE1
            BYTES_OUT <= lk_bytes;
            UNKNOWN_OUT <= ~lk_known;
         end
      end
   end

   // ----------------------------------------
   // wait-state count
   // ----------------------------------------
   always @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wait_q <= `WAIT_RESET; // RULE24
         MOVX_WAIT_COUNT_OUT <= `WAIT_RESET;
      end else begin
         if (WAIT_WE_IN) begin
            wait_q <= MOVX_WAIT_COUNT_IN; // RULE24
            MOVX_WAIT_COUNT_OUT <= MOVX_WAIT_COUNT_IN;
         end
      end
   end

   // ----------------------------------------
   // access pin strap, caught after release
   // ----------------------------------------
   always @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         strap_done_q <= 1'b0;
         INTERNAL_CODE_OUT <= 1'b0;
      end else begin
         if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            INTERNAL_CODE_OUT <= EXTERNAL_ACCESS_PIN_IN; // RULE13
         end
      end
   end

   // ----------------------------------------
   // stack pointer
   // ----------------------------------------
   always @* begin
      sp_d = sp_q;
      if (SP_WE_IN) begin
         sp_d = EXT_STACK_ENABLE_IN ? SP_WDATA_IN : {3'h0, SP_WDATA_IN[7:0]};
      end else if (STACK_PUSH_IN) begin
         sp_d = sp_inc(sp_q, EXT_STACK_ENABLE_IN); // RULE21
      end else if (STACK_POP_IN) begin
         sp_d = sp_dec(sp_q, EXT_STACK_ENABLE_IN);
      end
   end

   always @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sp_q <= {3'h0, `SP_RESET}; // RULE21
         STACK_TOP_POINTER_OUT <= `SP_RESET;
         STACK_POINTER_UPPER_BITS_OUT <= 3'h0;
      end else begin
         sp_q <= sp_d;
         STACK_TOP_POINTER_OUT <= sp_d[7:0];
         STACK_POINTER_UPPER_BITS_OUT <= sp_d[10:8]; // RULE22
      end
   end

   // ----------------------------------------
   // data and code map decode, registered
   // ----------------------------------------
   always @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         SEL_RAM_OUT <= 1'b0;
         SEL_SFR_OUT <= 1'b0;
         SEL_BANK_OUT <= 1'b0;
         BANK_NUM_OUT <= 2'h0;
         REG_NUM_OUT <= 3'h0;
         SEL_BITAREA_OUT <= 1'b0;
         BIT_BYTE_OUT <= 4'h0;
         XRAM_ONCHIP_OUT <= 1'b0;
         XRAM_OFFCHIP_OUT <= 1'b0;
         CODE_VALID_OUT <= 1'b0;
         FLASH_WRITE_OK_OUT <= 1'b0;
      end else begin
         // lower half any mode, upper half indirect only
         SEL_RAM_OUT <= ~DATA_ADDR_IN[`RAM_UPPER_BIT] | DATA_INDIRECT_IN; // RULE17
         SEL_SFR_OUT <= DATA_ADDR_IN[`RAM_UPPER_BIT] & ~DATA_INDIRECT_IN; // RULE18
         SEL_BANK_OUT <= (DATA_ADDR_IN <= `BANK_TOP); // RULE19
         BANK_NUM_OUT <= DATA_ADDR_IN[4:3];
         REG_NUM_OUT <= DATA_ADDR_IN[2:0];
         SEL_BITAREA_OUT <= (DATA_ADDR_IN >= `BITAREA_LO) &&
                            (DATA_ADDR_IN <= `BITAREA_HI); // RULE20
         BIT_BYTE_OUT <= DATA_ADDR_IN[3:0]; // bit address [6:3]
         // extended data space split
         XRAM_ONCHIP_OUT <= ONCHIP_XRAM_ENABLE_IN &&
                            (DATA_ADDRESS_POINTER_IN <= `XRAM_TOP); // RULE23
         XRAM_OFFCHIP_OUT <= !(ONCHIP_XRAM_ENABLE_IN &&
                               (DATA_ADDRESS_POINTER_IN <= `XRAM_TOP)); // RULE23
         // internal code only, nothing past the top
         CODE_VALID_OUT <= (CODE_ADDR_IN <= `CODE_TOP); // RULE14
         FLASH_WRITE_OK_OUT <= FLASH_WRITE_IN &&
                               (CODE_ADDR_IN <= `CODE_USER_TOP); // RULE15
      end
   end
   // data flash has no direct path here; it sits behind its own registers RULE16
endmodule // core_cycle_timing_and_memory_map

// ==== verif/core_timing_sva.sv ====
// checker for instruction timing, stack pointer and data map decode
// assumes it is bound into the top module and sees its ports only
`timescale 1ns/100ps
module core_timing_sva #(
   parameter WAIT_W = 3
) (
   // clock and reset
   input logic REF_CLK_IN,
   input logic RST_IN,
   // issue and status
   input logic ISSUE_IN,
   input logic [7:0] OPCODE_IN,
   input logic FROM_IRQ_IN,
   input logic BUSY_OUT,
   input logic DONE_OUT,
   input logic [3:0] CYCLES_OUT,
   input logic [1:0] BYTES_OUT,
   // wait count
   input logic [WAIT_W-1:0] MOVX_WAIT_COUNT_IN,
   input logic WAIT_WE_IN,
   input logic [WAIT_W-1:0] MOVX_WAIT_COUNT_OUT,
   // stack
   input logic STACK_PUSH_IN,
   input logic SP_WE_IN,
   input logic EXT_STACK_ENABLE_IN,
   input logic [7:0] STACK_TOP_POINTER_OUT,
   input logic [2:0] STACK_POINTER_UPPER_BITS_OUT,
   // data map
   input logic [7:0] DATA_ADDR_IN,
   input logic DATA_INDIRECT_IN,
   input logic SEL_RAM_OUT,
   input logic SEL_SFR_OUT
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   // issue seen by an idle sequencer
   wire take = ISSUE_IN && !BUSY_OUT;
   property p_long_call;
      take && OPCODE_IN == 8'h12 && !FROM_IRQ_IN |=> CYCLES_OUT == 4'h4 && BYTES_OUT == 2'h3;
   endproperty
   a_long_call: assert property (p_long_call) else $error("long call count wrong");
   property p_irq_call;
      take && OPCODE_IN == 8'h12 && FROM_IRQ_IN |=> CYCLES_OUT == 4'h3;
   endproperty
   a_irq_call: assert property (p_irq_call) else $error("vector call count wrong");
   property p_long_jump;
      take && OPCODE_IN == 8'h02 |=> (BUSY_OUT && !DONE_OUT) [*2] ##1 (BUSY_OUT && DONE_OUT)
         ##1 !BUSY_OUT;
   endproperty
   a_long_jump: assert property (p_long_jump) else $error("long jump timing wrong");
   property p_carry_op;
      take && OPCODE_IN == 8'hc3 |=> DONE_OUT && !BUSY_OUT && CYCLES_OUT == 4'h1
         && BYTES_OUT == 2'h1;
   endproperty
   a_carry_op: assert property (p_carry_op) else $error("carry op timing wrong");
   property p_movx;
      take && OPCODE_IN == 8'he0 |=> CYCLES_OUT == 4'h4 + {1'b0, $past(MOVX_WAIT_COUNT_OUT)};
   endproperty
   a_movx: assert property (p_movx) else $error("external move count wrong");
   property p_wait_load;
      WAIT_WE_IN |=> MOVX_WAIT_COUNT_OUT == $past(MOVX_WAIT_COUNT_IN);
   endproperty
   a_wait_load: assert property (p_wait_load) else $error("wait count not loaded");
   property p_push;
      STACK_PUSH_IN && !SP_WE_IN && !EXT_STACK_ENABLE_IN
         |=> STACK_TOP_POINTER_OUT == $past(STACK_TOP_POINTER_OUT) + 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push did not pre-increment");
   property p_ext_wrap;
      STACK_PUSH_IN && !SP_WE_IN && EXT_STACK_ENABLE_IN && STACK_TOP_POINTER_OUT == 8'hff
         && STACK_POINTER_UPPER_BITS_OUT == 3'h0
         |=> STACK_POINTER_UPPER_BITS_OUT == 3'h1 && STACK_TOP_POINTER_OUT == 8'h00;
   endproperty
   a_ext_wrap: assert property (p_ext_wrap) else $error("extended stack wrap wrong");
   property p_upper_half;
      DATA_ADDR_IN[7] |=> SEL_SFR_OUT == !$past(DATA_INDIRECT_IN)
         && SEL_RAM_OUT == $past(DATA_INDIRECT_IN);
   endproperty
   a_upper_half: assert property (p_upper_half) else $error("upper half select wrong");
endmodule // core_timing_sva

bind core_cycle_timing_and_memory_map core_timing_sva #(.WAIT_W(WAIT_W)) u_timing_sva (.*);

// ==== verif/tb_core_cycle_timing_and_memory_map.sv ====
// self-checking bench for the cycle sequencer, stack pointer and map decode
// assumes the design headers are on the include path
`timescale 1ns/100ps
module tb_core_cycle_timing_and_memory_map;
   logic REF_CLK_IN, RST_IN, EXTERNAL_ACCESS_PIN_IN, ISSUE_IN, FROM_IRQ_IN, WAIT_WE_IN;
   logic ONCHIP_XRAM_ENABLE_IN, EXT_STACK_ENABLE_IN, STACK_PUSH_IN, STACK_POP_IN, SP_WE_IN;
   logic DATA_INDIRECT_IN, FLASH_WRITE_IN;
   logic [7:0] OPCODE_IN, DATA_ADDR_IN;
   logic [2:0] MOVX_WAIT_COUNT_IN;
   logic [10:0] SP_WDATA_IN;
   logic [23:0] DATA_ADDRESS_POINTER_IN;
   logic [15:0] CODE_ADDR_IN;
   wire BUSY_OUT, DONE_OUT, UNKNOWN_OUT, INTERNAL_CODE_OUT, SEL_RAM_OUT, SEL_SFR_OUT;
   wire SEL_BANK_OUT, SEL_BITAREA_OUT, XRAM_ONCHIP_OUT, XRAM_OFFCHIP_OUT;
   wire CODE_VALID_OUT, FLASH_WRITE_OK_OUT;
   wire [3:0] CYCLES_OUT, BIT_BYTE_OUT;
   wire [1:0] BYTES_OUT, BANK_NUM_OUT;
   wire [2:0] MOVX_WAIT_COUNT_OUT, STACK_POINTER_UPPER_BITS_OUT, REG_NUM_OUT;
   wire [7:0] STACK_TOP_POINTER_OUT;
   int fail_count = 0;
   int n_tests = 0;

   core_cycle_timing_and_memory_map #(.WAIT_W(3)) uut (.*);

   // ------------------------------
   // helpers
   // ------------------------------
   // 100 MHz clock
   initial begin
      REF_CLK_IN = 1'b0;
      forever #5 REF_CLK_IN = ~REF_CLK_IN;
   end
   // step just past the next rising edge
   task automatic tick;
      @(posedge REF_CLK_IN);
      #1;
   endtask
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // counts, verdict, end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // a bounded wait ran out
   task automatic lost;
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out;
   endtask
   // reset for 8 cycles, then check reset state with the strap high
   task automatic do_reset;
      RST_IN = 1'b1;
      repeat (8) @(posedge REF_CLK_IN);
      #1;
      RST_IN = 1'b0;
      tick;
      tick;
      chk({INTERNAL_CODE_OUT, MOVX_WAIT_COUNT_OUT, STACK_TOP_POINTER_OUT}, 12'h807);
   endtask
   // issue one opcode, judge counts and done timing; one-cycle ops leave issue high
   task automatic run_op(input logic [7:0] op, input logic irq, input logic [1:0] b,
                         input logic [3:0] c);
      int k;
      OPCODE_IN = op;
      FROM_IRQ_IN = irq;
      ISSUE_IN = 1'b1;
      tick;
      if (c != 4'h1) ISSUE_IN = 1'b0;
      chk({UNKNOWN_OUT, BYTES_OUT, CYCLES_OUT}, {1'b0, b, c});
      k = 1;
      while (DONE_OUT !== 1'b1 && k < 20) begin
         tick;
         k++;
      end
      if (k == 20) lost;
      chk(k, (c == 4'h1) ? 1 : c - 1);
      k = 0;
      while (BUSY_OUT !== 1'b0 && k < 20) begin
         tick;
         k++;
      end
      if (k == 20) lost;
   endtask
   // back-to-back issue of up to eight opcodes of one class
   task automatic chk_list(input logic [63:0] ops, input int n, input logic [1:0] b,
                           input logic [3:0] c);
      for (int i = 0; i < n; i++) begin
         run_op(ops[8*i +: 8], 1'b0, b, c);
      end
      ISSUE_IN = 1'b0;
      tick;
   endtask
   // stack request pulse
   task automatic sp_op(input logic push, input logic pop, input logic we, input logic [10:0] wd);
      STACK_PUSH_IN = push;
      STACK_POP_IN = pop;
      SP_WE_IN = we;
      SP_WDATA_IN = wd;
      tick;
      STACK_PUSH_IN = 1'b0;
      STACK_POP_IN = 1'b0;
      SP_WE_IN = 1'b0;
      tick;
   endtask
   // internal data map: sel is {ram, sfr, bank, bitarea}
   task automatic dmap(input logic [7:0] a, input logic ind, input logic [3:0] sel,
                       input logic [4:0] fld);
      DATA_ADDR_IN = a;
      DATA_INDIRECT_IN = ind;
      tick;
      chk({SEL_RAM_OUT, SEL_SFR_OUT, SEL_BANK_OUT, SEL_BITAREA_OUT}, sel);
      if (sel[1]) chk({BANK_NUM_OUT, REG_NUM_OUT}, fld);
      if (sel[0]) chk(BIT_BYTE_OUT, fld[3:0]);
   endtask
   // extended data and code map: exp is {onchip, offchip, code valid, write ok}
   task automatic xmap(input logic en, input logic [23:0] p, input logic [15:0] ca,
                       input logic wr, input logic [3:0] exp);
      ONCHIP_XRAM_ENABLE_IN = en;
      DATA_ADDRESS_POINTER_IN = p;
      CODE_ADDR_IN = ca;
      FLASH_WRITE_IN = wr;
      tick;
      chk({XRAM_ONCHIP_OUT, XRAM_OFFCHIP_OUT, CODE_VALID_OUT, FLASH_WRITE_OK_OUT}, exp);
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   // every timed class except the external moves, back to back
   task automatic t_counts;
      chk_list({8'hc8, 8'hcf}, 2, 2'h1, 4'h1);
      chk_list({8'hc6, 8'hc7, 8'hd6, 8'hd7}, 4, 2'h1, 4'h2);
      chk_list(64'hc5, 1, 2'h2, 4'h2);
      chk_list({8'hc3, 8'hd3, 8'hb3, 8'h00}, 4, 2'h1, 4'h1);
      chk_list({8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2}, 8, 2'h2, 4'h2);
      chk_list(64'h92, 1, 2'h2, 4'h2);
      chk_list(64'h73, 1, 2'h1, 4'h3);
      chk_list({8'h01, 8'h11, 8'he1, 8'hf1, 8'h80}, 5, 2'h2, 4'h3);
      chk_list({8'h40, 8'h50, 8'h60, 8'h70, 8'hd8, 8'hdf}, 6, 2'h2, 4'h3);
      chk_list({8'h02, 8'h12}, 2, 2'h3, 4'h4);
      chk_list({8'h22, 8'h32}, 2, 2'h1, 4'h4);
      chk_list({8'h20, 8'h30, 8'h10, 8'hb5, 8'hb4, 8'hb8, 8'hbf, 8'hb6}, 8, 2'h3, 4'h4);
      chk_list({8'hd5, 8'hb7}, 2, 2'h3, 4'h4);
      run_op(8'h12, 1'b1, 2'h3, 4'h3);
      FROM_IRQ_IN = 1'b0;
   endtask
   // an issue during a long jump is dropped
   task automatic t_refused;
      OPCODE_IN = 8'h02;
      ISSUE_IN = 1'b1;
      tick;
      OPCODE_IN = 8'h00;
      tick;
      ISSUE_IN = 1'b0;
      tick;
      chk({BUSY_OUT, DONE_OUT, CYCLES_OUT}, 6'h34);
      tick;
      chk({BUSY_OUT, DONE_OUT, CYCLES_OUT}, 6'h04);
      OPCODE_IN = 8'h04;
      ISSUE_IN = 1'b1;
      tick;
      ISSUE_IN = 1'b0;
      chk({UNKNOWN_OUT, BYTES_OUT, CYCLES_OUT}, 7'h51);
   endtask
   // every wait count with an external move
   task automatic t_movx;
      logic [7:0] ops [6] = '{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
      for (int n = 0; n < 8; n++) begin
         MOVX_WAIT_COUNT_IN = n[2:0];
         WAIT_WE_IN = 1'b1;
         tick;
         WAIT_WE_IN = 1'b0;
         tick;
         chk(MOVX_WAIT_COUNT_OUT, n);
         run_op(ops[n % 6], 1'b0, 2'h1, 4'h4 + {1'b0, n[2:0]});
      end
   endtask
   // pre-increment, priority, extended roll-over and depth
   task automatic t_stack;
      sp_op(1'b1, 1'b0, 1'b0, 11'h000);
      chk({STACK_POINTER_UPPER_BITS_OUT, STACK_TOP_POINTER_OUT}, 11'h008);
      sp_op(1'b1, 1'b1, 1'b0, 11'h000);
      chk({STACK_POINTER_UPPER_BITS_OUT, STACK_TOP_POINTER_OUT}, 11'h009);
      EXT_STACK_ENABLE_IN = 1'b1;
      sp_op(1'b0, 1'b0, 1'b1, 11'h0ff);
      sp_op(1'b1, 1'b0, 1'b0, 11'h000);
      chk({STACK_POINTER_UPPER_BITS_OUT, STACK_TOP_POINTER_OUT}, 11'h100);
      sp_op(1'b0, 1'b1, 1'b0, 11'h000);
      chk({STACK_POINTER_UPPER_BITS_OUT, STACK_TOP_POINTER_OUT}, 11'h0ff);
      sp_op(1'b0, 1'b0, 1'b1, 11'h7fe);
      sp_op(1'b1, 1'b0, 1'b0, 11'h000);
      chk({STACK_POINTER_UPPER_BITS_OUT, STACK_TOP_POINTER_OUT}, 11'h7ff);
      EXT_STACK_ENABLE_IN = 1'b0;
      sp_op(1'b0, 1'b0, 1'b1, 11'h0ff);
      sp_op(1'b1, 1'b0, 1'b0, 11'h000);
      chk(STACK_TOP_POINTER_OUT, 8'h00);
   endtask
   // data and code map boundaries
   task automatic t_map;
      dmap(8'h05, 1'b0, 4'b1010, 5'h05);
      dmap(8'h1f, 1'b1, 4'b1010, 5'h1f);
      dmap(8'h20, 1'b0, 4'b1001, 5'h00);
      dmap(8'h2f, 1'b1, 4'b1001, 5'h0f);
      dmap(8'h30, 1'b0, 4'b1000, 5'h00);
      dmap(8'h7f, 1'b1, 4'b1000, 5'h00);
      dmap(8'h80, 1'b0, 4'b0100, 5'h00);
      dmap(8'hff, 1'b1, 4'b1000, 5'h00);
      xmap(1'b1, 24'h0007ff, 16'hf7ff, 1'b1, 4'b1010);
      xmap(1'b1, 24'h000800, 16'hf800, 1'b0, 4'b0100);
      xmap(1'b0, 24'h000000, 16'hdfff, 1'b1, 4'b0111);
      xmap(1'b1, 24'h000000, 16'he000, 1'b1, 4'b1010);
   endtask

   // main sequence
   initial begin
      EXTERNAL_ACCESS_PIN_IN = 1'b1;
      ISSUE_IN = 1'b0;
      OPCODE_IN = 8'h00;
      FROM_IRQ_IN = 1'b0;
      MOVX_WAIT_COUNT_IN = 3'h0;
      WAIT_WE_IN = 1'b0;
      ONCHIP_XRAM_ENABLE_IN = 1'b0;
      EXT_STACK_ENABLE_IN = 1'b0;
      STACK_PUSH_IN = 1'b0;
      STACK_POP_IN = 1'b0;
      SP_WE_IN = 1'b0;
      SP_WDATA_IN = 11'h000;
      DATA_ADDR_IN = 8'h00;
      DATA_INDIRECT_IN = 1'b0;
      DATA_ADDRESS_POINTER_IN = 24'h000000;
      CODE_ADDR_IN = 16'h0000;
      FLASH_WRITE_IN = 1'b0;
      do_reset;
      t_counts;
      t_refused;
      t_movx;
      t_stack;
      t_map;
      do_reset;
      close_out;
   end
endmodule // tb_core_cycle_timing_and_memory_map
